// ### design/pfr_defs.svh
// register offsets, reset values, field positions and timing counts of the rail and flash bank
`ifndef PFR_DEFS_SVH
`define PFR_DEFS_SVH

`define PFR_ADDR_LED_B_ON     8'h20
`define PFR_ADDR_LED_B_PH1    8'h21
`define PFR_ADDR_LED_B_PH2    8'h22
`define PFR_ADDR_LED_B_PH3    8'h23
`define PFR_ADDR_LED_B_PH4    8'h24
`define PFR_ADDR_LED_B_PER    8'h25
`define PFR_ADDR_LED_C_ON     8'h28
`define PFR_ADDR_LED_C_PH1    8'h29
`define PFR_ADDR_LED_C_PH2    8'h2a
`define PFR_ADDR_LED_C_PH3    8'h2b
`define PFR_ADDR_LED_C_PH4    8'h2c
`define PFR_ADDR_LED_C_PER    8'h2d
`define PFR_ADDR_CORE_EN      8'h3d
`define PFR_ADDR_CORE_V_LO    8'h3f
`define PFR_ADDR_CORE_V_HI    8'h40
`define PFR_ADDR_IO_EN        8'h45
`define PFR_ADDR_RF_EN        8'h4c
`define PFR_ADDR_RF_V         8'h4d

`define PFR_RST_LED           8'h00
`define PFR_RST_CORE_EN       8'h47
`define PFR_RST_CORE_V        5'h0c
`define PFR_RST_IO_EN         8'h45
`define PFR_RST_RF_EN         8'h03
`define PFR_RST_RF_V          5'h04

`define PFR_FLASH_EN_BIT      4
`define PFR_EN_MODE_BIT       1
`define PFR_EN_BUS_BIT        0
`define PFR_CORE_V_MAX        5'h18
`define PFR_RF_V_FLOOR        5'h04
`define PFR_RF_V_SECOND       5'h05
`define PFR_RF_V_TOP          5'h0b

`define PFR_TICK_MS           25
`define PFR_CLK_NS            100
`define PFR_TICK_CYCLES       ((`PFR_TICK_MS * 1000000) / `PFR_CLK_NS)

`endif

// ### design/pfr_pkg.sv
// types shared by the rail and flash register bank
package pfr_pkg;

  typedef struct packed {
    logic       flasher_enable;
    logic [3:0] onCode;
    logic [6:0] phase1;
    logic [6:0] phase2;
    logic [6:0] phase3;
    logic [6:0] phase4;
    logic [6:0] period;
  } pfr_flash_cfg_t;

  typedef enum logic [6:0] {
    PFR_IDLE = 7'h01,
    PFR_TON  = 7'h02,
    PFR_TP1  = 7'h04,
    PFR_TP2  = 7'h08,
    PFR_TP3  = 7'h10,
    PFR_TP4  = 7'h20,
    PFR_WAIT = 7'h40
  } pfr_flash_state_t;

endpackage

// ### design/pfr_flash_timer.sv
// flash sequencer for one current sink channel
`timescale 1ns/100ps
module pfr_flash_timer (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    tick,
  input  wire pfr_pkg::pfr_flash_cfg_t cfg,
  output logic                         sinkOn
);

  pfr_pkg::pfr_flash_state_t stateQ, stateD;
  logic [6:0] phaseCntQ, phaseCntD;
  logic [6:0] periodCntQ, periodCntD;
  logic       sinkOnD;
  logic [6:0] curLen;
  logic       restart;

  always_comb begin
    case (stateQ)
      pfr_pkg::PFR_TON: curLen = {3'h0, cfg.onCode} + 7'h01; // R7
      pfr_pkg::PFR_TP1: curLen = cfg.phase1; // R1
      pfr_pkg::PFR_TP2: curLen = cfg.phase2; // R2
      pfr_pkg::PFR_TP3: curLen = cfg.phase3; // R3
      pfr_pkg::PFR_TP4: curLen = cfg.phase4; // R4
      default:          curLen = 7'h00;
    endcase
  end

  // period code counts whole ticks; a zero period restarts on the next tick
  assign restart = tick && ((periodCntQ + 7'h01) >= cfg.period); // R5

  always_comb begin
    stateD     = stateQ;
    phaseCntD  = phaseCntQ;
    periodCntD = tick ? periodCntQ + 7'h01 : periodCntQ;
    if (!cfg.flasher_enable) begin // R6
      stateD     = pfr_pkg::PFR_IDLE;
      phaseCntD  = 7'h00;
      periodCntD = 7'h00;
    end else if (stateQ == pfr_pkg::PFR_IDLE || restart) begin // R16
      stateD     = pfr_pkg::PFR_TON;
      phaseCntD  = 7'h00;
      periodCntD = 7'h00;
    end else begin
      case (stateQ)
        pfr_pkg::PFR_TON, pfr_pkg::PFR_TP1, pfr_pkg::PFR_TP2,
        pfr_pkg::PFR_TP3, pfr_pkg::PFR_TP4: begin
          // zero-length phases fall through without waiting for a tick
          if (curLen == 7'h00 || (tick && phaseCntQ + 7'h01 >= curLen)) begin // R16
            phaseCntD = 7'h00;
            case (stateQ)
              pfr_pkg::PFR_TON: stateD = pfr_pkg::PFR_TP1;
              pfr_pkg::PFR_TP1: stateD = pfr_pkg::PFR_TP2;
              pfr_pkg::PFR_TP2: stateD = pfr_pkg::PFR_TP3;
              pfr_pkg::PFR_TP3: stateD = pfr_pkg::PFR_TP4;
              default:          stateD = pfr_pkg::PFR_WAIT;
            endcase
          end else if (tick) begin
            phaseCntD = phaseCntQ + 7'h01;
          end
        end
        pfr_pkg::PFR_WAIT: stateD = pfr_pkg::PFR_WAIT;
        default:           stateD = pfr_pkg::PFR_IDLE;
      endcase
    end
    // lit in on-time and even phases; a zero phase still costs one cycle,
    // so it shows the level of the next timed phase instead of a blip
    case (stateD)
      pfr_pkg::PFR_TON: sinkOnD = 1'b1; // R16
      pfr_pkg::PFR_TP1: sinkOnD = (cfg.phase1 == 7'h00) && ((cfg.phase2 != 7'h00)
                                  || ((cfg.phase3 == 7'h00) && (cfg.phase4 != 7'h00))); // R16
      pfr_pkg::PFR_TP2: sinkOnD = (cfg.phase2 != 7'h00)
                                  || ((cfg.phase3 == 7'h00) && (cfg.phase4 != 7'h00)); // R16
      pfr_pkg::PFR_TP3: sinkOnD = (cfg.phase3 == 7'h00) && (cfg.phase4 != 7'h00); // R16
      pfr_pkg::PFR_TP4: sinkOnD = (cfg.phase4 != 7'h00); // R16
      default:          sinkOnD = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateQ     <= pfr_pkg::PFR_IDLE;
      phaseCntQ  <= 7'h00;
      periodCntQ <= 7'h00;
      sinkOn     <= 1'b0;
    end else begin
      stateQ     <= stateD;
      phaseCntQ  <= phaseCntD;
      periodCntQ <= periodCntD;
      sinkOn     <= sinkOnD;
    end
  end

  a_flash_off_dark : assert property (@(posedge clk) disable iff (sys_rst) // R6
    !cfg.flasher_enable |=> !sinkOn)
    else $error("sink lit while flasher disabled");

  a_flash_start_on : assert property (@(posedge clk) disable iff (sys_rst) // R16
    (cfg.flasher_enable && stateQ == pfr_pkg::PFR_IDLE) |=> sinkOn)
    else $error("flash sequence did not begin with on-time");

endmodule

// ### design/pfr_regs.sv
// register bank for two flash channels and the core, io and rf rails
`timescale 1ns/100ps
`include "pfr_defs.svh"

// Overview of operation
// (R1) first phase time: 7-bit, 25 ms steps
// (R2) second phase time: 7-bit, 25 ms steps
// (R3) third phase time: 7-bit, 25 ms steps
// (R4) fourth phase time: 7-bit, reset zero
// (R5) flash period: 7-bit, 25 ms steps
// (R6) bit 4 enables flasher, reset off
// (R7) on-time code n gives (n+1)*25 ms
// (R8) core enable: bus or group D request
// (R9) core enable register resets to 0x47
// (R10) select pin picks low or high voltage register
// (R11) core code linear, top codes saturate 1.200 V
// (R12) both core voltage registers reset 0x0c
// (R13) io enable group A, reset 0x45
// (R14) rf enable group B, reset 0x03
// (R15) rf voltage code table, reset 04
// (R16) flash: on-time, four phases, repeat each period
module pfr_regs #(
  parameter int TICK_CYCLES = `PFR_TICK_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic [7:0] regRdAddr,
  output logic      [7:0] regRdData,
  input  wire logic       powerReqGroupA,
  input  wire logic       powerReqGroupB,
  input  wire logic       powerReqGroupD,
  input  wire logic       voltageSelectPin,
  output logic            currentSinkB,
  output logic            currentSinkC,
  output logic            coreStepDownOn,
  output logic            ioStepDownOn,
  output logic            rfLinearOn,
  output logic      [4:0] coreVoltStep,
  output logic      [2:0] rfVoltStep
);

  generate
    if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
    end
  endgenerate

  // flash settings per channel, B then C
  pfr_pkg::pfr_flash_cfg_t flashQ [2];
  pfr_pkg::pfr_flash_cfg_t flashD [2];
  logic [7:0] coreEnQ, coreEnD;
  logic [7:0] ioEnQ, ioEnD;
  logic [7:0] rfEnQ, rfEnD;
  logic [4:0] coreVLoQ, coreVLoD;
  logic [4:0] coreVHiQ, coreVHiD;
  logic [4:0] rfVQ, rfVD;
  logic [7:0] rdD;
  logic [31:0] tickCntQ, tickCntD;
  logic        tickQ, tickD;
  logic        coreOnD, ioOnD, rfOnD;
  logic [4:0]  coreSel;
  logic [4:0]  coreStepD;
  logic [2:0]  rfStepD;

  // 25 ms time base shared by both flashers
  always_comb begin
    tickD    = 1'b0;
    tickCntD = tickCntQ + 32'h1;
    if (tickCntQ >= 32'(TICK_CYCLES - 1)) begin
      tickCntD = 32'h0;
      tickD    = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tickCntQ <= 32'h0;
      tickQ    <= 1'b0;
    end else begin
      tickCntQ <= tickCntD;
      tickQ    <= tickD;
    end
  end

  // register writes
  always_comb begin
    flashD   = flashQ;
    coreEnD  = coreEnQ;
    ioEnD    = ioEnQ;
    rfEnD    = rfEnQ;
    coreVLoD = coreVLoQ;
    coreVHiD = coreVHiQ;
    rfVD     = rfVQ;
    if (regWrEn) begin
      case (regWrAddr)
        `PFR_ADDR_LED_B_ON: begin
          flashD[0].flasher_enable = regWrData[`PFR_FLASH_EN_BIT]; // R6
          flashD[0].onCode  = regWrData[3:0]; // R7
        end
        `PFR_ADDR_LED_B_PH1: flashD[0].phase1 = regWrData[6:0]; // R1
        `PFR_ADDR_LED_B_PH2: flashD[0].phase2 = regWrData[6:0]; // R2
        `PFR_ADDR_LED_B_PH3: flashD[0].phase3 = regWrData[6:0]; // R3
        `PFR_ADDR_LED_B_PH4: flashD[0].phase4 = regWrData[6:0]; // R4
        `PFR_ADDR_LED_B_PER: flashD[0].period = regWrData[6:0]; // R5
        `PFR_ADDR_LED_C_ON: begin
          flashD[1].flasher_enable = regWrData[`PFR_FLASH_EN_BIT]; // R6
          flashD[1].onCode  = regWrData[3:0]; // R7
        end
        `PFR_ADDR_LED_C_PH1: flashD[1].phase1 = regWrData[6:0]; // R1
        `PFR_ADDR_LED_C_PH2: flashD[1].phase2 = regWrData[6:0]; // R2
        `PFR_ADDR_LED_C_PH3: flashD[1].phase3 = regWrData[6:0]; // R3
        `PFR_ADDR_LED_C_PH4: flashD[1].phase4 = regWrData[6:0]; // R4
        `PFR_ADDR_LED_C_PER: flashD[1].period = regWrData[6:0]; // R5
        // enable registers keep all eight bits so reserved reset bits read back
        `PFR_ADDR_CORE_EN:   coreEnD  = regWrData; // R8
        `PFR_ADDR_IO_EN:     ioEnD    = regWrData; // R13
        `PFR_ADDR_RF_EN:     rfEnD    = regWrData; // R14
        `PFR_ADDR_CORE_V_LO: coreVLoD = regWrData[4:0]; // R10
        `PFR_ADDR_CORE_V_HI: coreVHiD = regWrData[4:0]; // R10
        `PFR_ADDR_RF_V:      rfVD     = regWrData[4:0]; // R15
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 2; i++) begin
        flashQ[i] <= '0; // R1 R2 R3 R4 R5 R6
      end
      coreEnQ  <= `PFR_RST_CORE_EN; // R9
      ioEnQ    <= `PFR_RST_IO_EN; // R13
      rfEnQ    <= `PFR_RST_RF_EN; // R14
      coreVLoQ <= `PFR_RST_CORE_V; // R12
      coreVHiQ <= `PFR_RST_CORE_V; // R12
      rfVQ     <= `PFR_RST_RF_V; // R15
    end else begin
      flashQ   <= flashD;
      coreEnQ  <= coreEnD;
      ioEnQ    <= ioEnD;
      rfEnQ    <= rfEnD;
      coreVLoQ <= coreVLoD;
      coreVHiQ <= coreVHiD;
      rfVQ     <= rfVD;
    end
  end

  // register reads; reserved bits of flash and voltage registers and unmapped addresses read zero
  always_comb begin
    case (regRdAddr)
      `PFR_ADDR_LED_B_ON:  rdD = {3'h0, flashQ[0].flasher_enable, flashQ[0].onCode};
      `PFR_ADDR_LED_B_PH1: rdD = {1'b0, flashQ[0].phase1};
      `PFR_ADDR_LED_B_PH2: rdD = {1'b0, flashQ[0].phase2};
      `PFR_ADDR_LED_B_PH3: rdD = {1'b0, flashQ[0].phase3};
      `PFR_ADDR_LED_B_PH4: rdD = {1'b0, flashQ[0].phase4};
      `PFR_ADDR_LED_B_PER: rdD = {1'b0, flashQ[0].period};
      `PFR_ADDR_LED_C_ON:  rdD = {3'h0, flashQ[1].flasher_enable, flashQ[1].onCode};
      `PFR_ADDR_LED_C_PH1: rdD = {1'b0, flashQ[1].phase1};
      `PFR_ADDR_LED_C_PH2: rdD = {1'b0, flashQ[1].phase2};
      `PFR_ADDR_LED_C_PH3: rdD = {1'b0, flashQ[1].phase3};
      `PFR_ADDR_LED_C_PH4: rdD = {1'b0, flashQ[1].phase4};
      `PFR_ADDR_LED_C_PER: rdD = {1'b0, flashQ[1].period};
      `PFR_ADDR_CORE_EN:   rdD = coreEnQ;
      `PFR_ADDR_CORE_V_LO: rdD = {3'h0, coreVLoQ};
      `PFR_ADDR_CORE_V_HI: rdD = {3'h0, coreVHiQ};
      `PFR_ADDR_IO_EN:     rdD = ioEnQ;
      `PFR_ADDR_RF_EN:     rdD = rfEnQ;
      `PFR_ADDR_RF_V:      rdD = {3'h0, rfVQ};
      default:             rdD = 8'h00;
    endcase
  end

  // rail enables: mode bit hands control to the request pin of the group
  always_comb begin
    coreOnD = coreEnQ[`PFR_EN_MODE_BIT] ? powerReqGroupD : coreEnQ[`PFR_EN_BUS_BIT]; // R8
    ioOnD   = ioEnQ[`PFR_EN_MODE_BIT] ? powerReqGroupA : ioEnQ[`PFR_EN_BUS_BIT]; // R13
    rfOnD   = rfEnQ[`PFR_EN_MODE_BIT] ? powerReqGroupB : rfEnQ[`PFR_EN_BUS_BIT]; // R14
  end

  // voltage steps: core in 25 mV above 0.600 V, rf in 50 mV above 2.65 V
  always_comb begin
    coreSel   = voltageSelectPin ? coreVHiQ : coreVLoQ; // R10
    coreStepD = (coreSel[4:3] == 2'b11) ? `PFR_CORE_V_MAX : coreSel; // R11
    if (rfVQ < `PFR_RF_V_FLOOR) begin // R15
      rfStepD = 3'h0;
    end else if (rfVQ <= `PFR_RF_V_SECOND) begin
      rfStepD = 3'h1;
    end else if (rfVQ <= `PFR_RF_V_TOP) begin
      rfStepD = 3'(rfVQ - `PFR_RF_V_FLOOR);
    end else begin
      rfStepD = 3'h7;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData      <= 8'h00;
      coreStepDownOn <= 1'b0;
      ioStepDownOn   <= 1'b0;
      rfLinearOn     <= 1'b0;
      coreVoltStep   <= 5'h00;
      rfVoltStep     <= 3'h0;
    end else begin
      regRdData      <= rdD;
      coreStepDownOn <= coreOnD;
      ioStepDownOn   <= ioOnD;
      rfLinearOn     <= rfOnD;
      coreVoltStep   <= coreStepD;
      rfVoltStep     <= rfStepD;
    end
  end

  pfr_flash_timer u_flash_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tickQ),
    .cfg     (flashQ[0]),
    .sinkOn  (currentSinkB)
  );

  pfr_flash_timer u_flash_c (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tickQ),
    .cfg     (flashQ[1]),
    .sinkOn  (currentSinkC)
  );

  sequence s_core_write_lo;
    regWrEn && regWrAddr == `PFR_ADDR_CORE_V_LO && regWrData[4:3] != 2'b11;
  endsequence

  a_core_sel_low : assert property (@(posedge clk) disable iff (sys_rst) // R10
    (s_core_write_lo ##1 !voltageSelectPin) |=> coreVoltStep == $past(regWrData[4:0], 2))
    else $error("core step not taken from low register");

  a_core_sel_high : assert property (@(posedge clk) disable iff (sys_rst) // R10
    voltageSelectPin && coreVHiQ[4:3] != 2'b11 |=> coreVoltStep == $past(coreVHiQ))
    else $error("core step not taken from high register");

  a_core_clamp : assert property (@(posedge clk) disable iff (sys_rst) // R11
    coreVoltStep <= `PFR_CORE_V_MAX)
    else $error("core step above saturation");

  a_core_reset_sel : assert property (@(posedge clk) // R12
    $fell(sys_rst) |=> coreVoltStep == `PFR_RST_CORE_V)
    else $error("core step not 0x0c after reset");

  a_core_enable_req : assert property (@(posedge clk) disable iff (sys_rst) // R8
    coreEnQ[1] |=> coreStepDownOn == $past(powerReqGroupD))
    else $error("core rail ignores request pin");

  a_io_enable_bus : assert property (@(posedge clk) disable iff (sys_rst) // R13
    !ioEnQ[1] |=> ioStepDownOn == $past(ioEnQ[0]))
    else $error("io rail ignores bus enable");

  a_rf_enable_req : assert property (@(posedge clk) disable iff (sys_rst) // R14
    rfEnQ[1] |=> rfLinearOn == $past(powerReqGroupB))
    else $error("rf rail ignores request pin");

  a_rf_step_map : assert property (@(posedge clk) disable iff (sys_rst) // R15
    (rfVQ >= 5'h0c) ##1 (rfVQ >= 5'h0c) |-> rfVoltStep == 3'h7)
    else $error("rf step not saturated");

  a_core_rd_reset : assert property (@(posedge clk) // R9
    $fell(sys_rst) && regRdAddr == `PFR_ADDR_CORE_EN |=> regRdData == `PFR_RST_CORE_EN)
    else $error("core enable not 0x47 after reset");

  a_phase_rd_back : assert property (@(posedge clk) disable iff (sys_rst) // R1
    regWrEn && regWrAddr == `PFR_ADDR_LED_B_PH1 ##1 regRdAddr == `PFR_ADDR_LED_B_PH1
    && !(regWrEn && regWrAddr == `PFR_ADDR_LED_B_PH1) |=> regRdData == {1'b0, $past(regWrData[6:0], 2)})
    else $error("phase one readback wrong");

  a_core_lo_sat : assert property (@(posedge clk) disable iff (sys_rst) // R11
    (!voltageSelectPin && coreVLoQ[4:3] == 2'b11) |=> coreVoltStep == `PFR_CORE_V_MAX)
    else $error("core step from low register not saturated");

  a_io_enable_req : assert property (@(posedge clk) disable iff (sys_rst) // R13
    ioEnQ[`PFR_EN_MODE_BIT] |=> ioStepDownOn == $past(powerReqGroupA))
    else $error("io rail ignores request pin");

  a_rf_step_floor : assert property (@(posedge clk) disable iff (sys_rst) // R15
    (rfVQ < `PFR_RF_V_FLOOR) |=> rfVoltStep == 3'h0)
    else $error("rf step not at floor for low codes");

  // read port answers one cycle after the address, from the stored code
  a_rd_high_reg : assert property (@(posedge clk) disable iff (sys_rst) // R10
    (regRdAddr == `PFR_ADDR_CORE_V_HI) |=> regRdData == {3'h0, $past(coreVHiQ)})
    else $error("high voltage register readback wrong");

endmodule

// ### verif/pfr_host_model.sv
// host side of the register port: write and read cycles
`timescale 1ns/100ps
module pfr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output logic            regWrEn,
  output logic      [7:0] regWrAddr,
  output logic      [7:0] regWrData,
  output logic      [7:0] regRdAddr
);
  initial begin
    regWrEn = 1'b0;
    regWrAddr = 8'h00;
    regWrData = 8'h00;
    regRdAddr = 8'h00;
  end

  // strobe dropped one edge later so back-to-back calls never clash
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regWrAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask

  // read data is registered, so sampled one edge after the address is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRdAddr <= a;
    @(posedge clk);
    @(posedge clk);
    #1;
    d = regRdData;
  endtask
endmodule

// ### verif/pfr_regs_tb.sv
// self-checking bench for the rail and flash register bank
`timescale 1ns/100ps
module pfr_regs_tb;
  localparam int TICK = 4;
  localparam logic [7:0] ADDR [18] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h28,
    8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h3d, 8'h3f, 8'h40, 8'h45, 8'h4c, 8'h4d};
  localparam logic [7:0] RSTV [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h47, 8'h0c, 8'h0c, 8'h45, 8'h03, 8'h04};
  localparam logic [7:0] MASK [18] = '{8'h1f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h1f,
    8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h1f, 8'h1f, 8'hff, 8'hff, 8'h1f};

  logic       clk = 1'b0;
  logic       sysRst = 1'b1;
  logic       regWrEn;
  logic [7:0] regWrAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdAddr;
  logic [7:0] regRdData;
  logic       powerReqGroupA = 1'b0;
  logic       powerReqGroupB = 1'b0;
  logic       powerReqGroupD = 1'b0;
  logic       voltageSelectPin = 1'b0;
  logic       currentSinkB;
  logic       currentSinkC;
  logic       coreStepDownOn;
  logic       ioStepDownOn;
  logic       rfLinearOn;
  logic [4:0] coreVoltStep;
  logic [2:0] rfVoltStep;
  int         fail_count = 0;
  int         check_count = 0;
  int         cycles = 0;
  logic [7:0] rdv;
  int         n;

  always #50 clk = ~clk;

  pfr_regs #(.TICK_CYCLES(TICK)) i_pfr_regs (.clk(clk), .sys_rst(sysRst),
    .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .powerReqGroupA(powerReqGroupA),
    .powerReqGroupB(powerReqGroupB), .powerReqGroupD(powerReqGroupD),
    .voltageSelectPin(voltageSelectPin), .currentSinkB(currentSinkB),
    .currentSinkC(currentSinkC), .coreStepDownOn(coreStepDownOn),
    .ioStepDownOn(ioStepDownOn), .rfLinearOn(rfLinearOn),
    .coreVoltStep(coreVoltStep), .rfVoltStep(rfVoltStep));

  pfr_host_model i_pfr_host_model (.clk(clk), .regRdData(regRdData), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdAddr(regRdAddr));

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  // length of the current run of one level on a sink, bounded
  task automatic run_len(input bit ch, input logic lvl, output int len);
    len = 0;
    while ((ch ? currentSinkC : currentSinkB) === lvl && len < 400) begin
      settle();
      len++;
    end
  endtask

  // after one partial period, the next period's runs are whole ticks
  task automatic flash_runs(input bit ch, input int skip, input int exp [4], input int cnt);
    run_len(ch, 1'b0, n);
    for (int i = 0; i < skip; i++)
      run_len(ch, (i % 2 == 0), n);
    for (int i = 0; i < cnt; i++) begin
      run_len(ch, (i % 2 == 0), n);
      check(ch ? "sinkC run" : "sinkB run", 8'(exp[i]), 8'(n));
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      $display("ERROR timeout expected done seen hang");
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    repeat (2) settle();
    check("coreVoltStep rst", 8'h0c, {3'h0, coreVoltStep});
    check("rfVoltStep rst", 8'h01, {5'h00, rfVoltStep});
    check("ioOn rst", 8'h01, {7'h00, ioStepDownOn});
    check("coreOn rst", 8'h00, {7'h00, coreStepDownOn});
    for (int i = 0; i < 18; i++) begin
      i_pfr_host_model.rd(ADDR[i], rdv);
      check("reset value", RSTV[i], rdv);
      i_pfr_host_model.wr(ADDR[i], 8'hff);
      i_pfr_host_model.rd(ADDR[i], rdv);
      check("field width", MASK[i], rdv);
      i_pfr_host_model.wr(ADDR[i], RSTV[i]);
    end
    i_pfr_host_model.wr(8'h30, 8'h5a);
    i_pfr_host_model.rd(8'h30, rdv);
    check("unmapped", 8'h00, rdv);
    for (int m = 0; m < 4; m++)
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        // three distinct pin patterns so a swapped group shows up
        powerReqGroupA <= p[0];
        powerReqGroupB <= p[1];
        powerReqGroupD <= p[0] ^ p[1];
        i_pfr_host_model.wr(8'h3d, 8'(m));
        i_pfr_host_model.wr(8'h45, 8'(m));
        i_pfr_host_model.wr(8'h4c, 8'(m));
        settle();
        check("coreOn", {7'h0, m[1] ? p[0] ^ p[1] : m[0]}, {7'h0, coreStepDownOn});
        check("ioOn", {7'h0, m[1] ? p[0] : m[0]}, {7'h0, ioStepDownOn});
        check("rfOn", {7'h0, m[1] ? p[1] : m[0]}, {7'h0, rfLinearOn});
      end
    i_pfr_host_model.wr(8'h40, 8'h1b);
    for (int c = 0; c < 32; c++) begin
      i_pfr_host_model.wr(8'h3f, 8'(c));
      i_pfr_host_model.wr(8'h4d, 8'(c));
      settle();
      check("coreVoltStep", (c >= 24) ? 8'h18 : 8'(c), {3'h0, coreVoltStep});
      check("rfVoltStep", (c < 4) ? 8'h0 : (c < 6) ? 8'h1 : (c < 12) ? 8'(c - 4) : 8'h7,
        {5'h0, rfVoltStep});
    end
    // low register now saturated, high one not, so the pin choice is visible
    i_pfr_host_model.wr(8'h40, 8'h0a);
    @(posedge clk);
    voltageSelectPin <= 1'b1;
    repeat (2) settle();
    check("core high reg", 8'h0a, {3'h0, coreVoltStep});
    @(posedge clk);
    voltageSelectPin <= 1'b0;
    repeat (2) settle();
    check("core low reg", 8'h18, {3'h0, coreVoltStep});
    // sink b: on code 0, no phases, period code 3
    i_pfr_host_model.wr(8'h25, 8'h03);
    i_pfr_host_model.wr(8'h20, 8'h10);
    flash_runs(1'b0, 2, '{TICK, 2 * TICK, 0, 0}, 2);
    // sink c: on code 1, dark phase 2, lit phase 1, zero phases skipped
    i_pfr_host_model.wr(8'h29, 8'h02);
    i_pfr_host_model.wr(8'h2a, 8'h01);
    i_pfr_host_model.wr(8'h2d, 8'h14);
    i_pfr_host_model.wr(8'h28, 8'h11);
    flash_runs(1'b1, 4, '{2 * TICK, 2 * TICK, TICK, 15 * TICK}, 4);
    i_pfr_host_model.wr(8'h28, 8'h01);
    settle();
    check("sinkC off", 8'h00, {7'h0, currentSinkC});
    repeat (3 * TICK) settle();
    check("sinkC stays off", 8'h00, {7'h0, currentSinkC});
    // second reset in mid-run with sink b still flashing
    i_pfr_host_model.rd(8'h3d, rdv);
    check("core enable", 8'h03, rdv);
    @(posedge clk);
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    repeat (2) settle();
    check("core enable rerst", 8'h47, regRdData);
    check("coreVoltStep rerst", 8'h0c, {3'h0, coreVoltStep});
    repeat (3 * TICK) settle();
    check("sinkB rerst", 8'h00, {7'h0, currentSinkB});
    test_done();
  end
endmodule
